/* hw/rx_wake_pkg.sv */
// shared constants and carrier types for the standby-wake receive channel
// assumes one 125 MHz operation clock and the plain register port of the top
package rx_wake_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_STANDBY_CTRL = 8'h00;
  localparam logic [7:0] OFS_START_TRIG = 8'h04;
  localparam logic [7:0] OFS_STOP_TRIG = 8'h08;
  localparam logic [7:0] OFS_DATA_BUF = 8'h0c;
  localparam logic [7:0] OFS_FRAME_CFG = 8'h10;
  localparam logic [7:0] OFS_CHAN_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h1c;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h20;
  localparam logic [7:0] OFS_ERR_CLEAR = 8'h24;
  // field positions
  localparam int WAKE_BIT = 0;
  localparam int ERRSEL_BIT = 1;
  localparam int CHAN_IDX = 1;
  localparam int DIV_LSB = 9;
  localparam int DIV_W = 7;
  localparam int PAR_EN_BIT = 0;
  localparam int PAR_ODD_BIT = 1;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ERR_BIT = 1;
  localparam int IRQ_W = 2;
  // reset values
  localparam logic [6:0] DIV_RESET = 7'h00;
  localparam logic [1:0] STANDBY_RESET = 2'h0;
  localparam logic [1:0] FRAME_CFG_RESET = 2'h0;
  localparam logic [IRQ_W-1:0] IRQ_EN_RESET = 2'h0;
  localparam int DATA_BITS = 8;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } reg_req_s;

  // per-channel error flags, kept across a stop trigger
  typedef struct packed {
    logic ovf;
    logic pef;
    logic fef;
  } err_flags_s;

  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP} rx_state_e;
endpackage

/* hw/sync2.sv */
// two-flop synchroniser for one asynchronous pin level
// assumes the pin idles at the RESET_VAL level
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic sys_clk, // operation clock
  input wire logic rstn, // async reset, active low
  input wire logic d_async, // raw pin level
  output logic q_sync // level safe to use
);
  logic meta_q;

  // first flop feeds only the second
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= RESET_VAL;
      q_sync <= RESET_VAL;
    end else begin
      meta_q <= d_async;
      q_sync <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* hw/bit_timer.sv */
// bit timer: one bit lasts 2*(div+1) clocks, sample strobe in the middle
// assumes restart is pulsed on the edge that opens a bit
`timescale 1ns/10ps
`default_nettype none
module bit_timer #(
  parameter int DIV_W = 7
) (
  input wire logic sys_clk, // operation clock
  input wire logic rstn, // async reset, active low
  input wire logic restart, // realign count to a bit edge
  input wire logic [DIV_W-1:0] div, // divider field
  output logic sample // one-cycle mid-bit strobe
);
  logic [DIV_W:0] cnt_q;
  logic [DIV_W:0] cnt_d;
  wire [DIV_W:0] half = {1'b0, div} + {{DIV_W{1'b0}}, 1'b1};
  wire [DIV_W:0] last = {div, 1'b1};

  // wraps after an even number of clocks, 2 up to 256
  assign cnt_d = (restart || cnt_q == last) ? '0 : cnt_q + 1'b1;
  assign sample = !restart && (cnt_q == half - 1'b1);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule
`default_nettype wire

/* hw/rx_wake_ctrl.sv */
// receive channel with stop-state wake, start/stop triggers and data buffer
// assumes stop_mode comes from the power controller on sys_clk; rxd is a raw pin
`timescale 1ns/10ps
`default_nettype none
module rx_wake_ctrl #(
  parameter int DIV_W = rx_wake_pkg::DIV_W
) (
  input wire logic sys_clk, // 125 MHz operation clock
  input wire logic rstn, // async reset, active low
  input wire logic [7:0] addr, // register byte address
  input wire logic [15:0] wr_data, // write data
  input wire logic wr_stb, // write strobe
  input wire logic rd_stb, // read strobe
  output logic [15:0] rd_data, // read data, cycle after rd_stb
  input wire logic stop_mode, // device is in stop state
  input wire logic rxd, // serial receive pin
  output logic clk_req, // clock request to clock generator
  output logic irq // level interrupt
);
  rx_wake_pkg::reg_req_s req;
  rx_wake_pkg::rx_state_e state_q;
  rx_wake_pkg::rx_state_e state_d;
  rx_wake_pkg::err_flags_s err_q;
  logic wake_q, errsel_q, chan_en_q, par_en_q, par_odd_q, full_q, clk_req_q;
  logic [DIV_W-1:0] div_q;
  logic [7:0] rx_data_q, shift_q;
  logic [2:0] bitcnt_q;
  logic par_bit_q, rx_prev_q;
  logic [rx_wake_pkg::IRQ_W-1:0] irq_st_q, irq_en_q;
  logic [15:0] rd_data_q;
  logic rx_s, smp;

  assign req = '{wr: wr_stb, rd: rd_stb, addr: addr, wdata: wr_data};

  // pin passes two flops before anything looks at it
  sync2 #(.RESET_VAL(1'b1)) u_rx_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .d_async(rxd),
    .q_sync(rx_s)
  );

  // address decode
  wire wr_ctrl = req.wr && req.addr == rx_wake_pkg::OFS_STANDBY_CTRL;
  wire wr_start = req.wr && req.addr == rx_wake_pkg::OFS_START_TRIG;
  wire wr_stop = req.wr && req.addr == rx_wake_pkg::OFS_STOP_TRIG;
  wire wr_data_buf = req.wr && req.addr == rx_wake_pkg::OFS_DATA_BUF;
  wire wr_cfg = req.wr && req.addr == rx_wake_pkg::OFS_FRAME_CFG;
  wire wr_irq_clr = req.wr && req.addr == rx_wake_pkg::OFS_IRQ_CLEAR;
  wire wr_irq_en = req.wr && req.addr == rx_wake_pkg::OFS_IRQ_ENABLE;
  wire wr_err_clr = req.wr && req.addr == rx_wake_pkg::OFS_ERR_CLEAR;
  wire rd_data_buf = req.rd && req.addr == rx_wake_pkg::OFS_DATA_BUF;
  // only the bit of this channel acts; writing 0 is no trigger
  wire start_trig = wr_start && req.wdata[rx_wake_pkg::CHAN_IDX];
  wire stop_trig = wr_stop && req.wdata[rx_wake_pkg::CHAN_IDX];

  wire can_start = chan_en_q && (!stop_mode || wake_q);
  wire fall = rx_prev_q && !rx_s;
  wire start_det = state_q == rx_wake_pkg::ST_IDLE && can_start && fall &&
                   !stop_trig && !start_trig;
  wire false_start = state_q == rx_wake_pkg::ST_START && smp && rx_s;
  wire in_stop_bit = state_q == rx_wake_pkg::ST_STOP && smp;
  wire pe_now = par_en_q && (par_bit_q != (^shift_q ^ par_odd_q));
  wire fe_now = !rx_s;
  wire frame_done = in_stop_bit && !stop_trig;
  wire frame_err = fe_now || pe_now;
  wire ovf_now = full_q;
  // error interrupts only while select is 0
  wire done_ev = frame_done && !frame_err && !ovf_now;
  wire err_ev = frame_done && (frame_err || ovf_now) && !errsel_q;
  wire [rx_wake_pkg::IRQ_W-1:0] irq_ev = {err_ev, done_ev};

  // resync on every falling edge during the data bits while wake is set
  wire realign = wake_q && fall && state_q == rx_wake_pkg::ST_DATA;

  // transfer clock from the upper divider field
  bit_timer #(.DIV_W(DIV_W)) u_bit_timer (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .restart(start_det || realign),
    .div(div_q),
    .sample(smp)
  );

  // frame sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      rx_wake_pkg::ST_IDLE: begin
        if (start_det) state_d = rx_wake_pkg::ST_START;
      end
      rx_wake_pkg::ST_START: begin
        if (smp) state_d = rx_s ? rx_wake_pkg::ST_IDLE : rx_wake_pkg::ST_DATA;
      end
      rx_wake_pkg::ST_DATA: begin
        if (smp && bitcnt_q == 3'h7) begin
          state_d = par_en_q ? rx_wake_pkg::ST_PARITY : rx_wake_pkg::ST_STOP;
        end
      end
      rx_wake_pkg::ST_PARITY: begin
        if (smp) state_d = rx_wake_pkg::ST_STOP;
      end
      rx_wake_pkg::ST_STOP: begin
        if (smp) state_d = rx_wake_pkg::ST_IDLE;
      end
      default: state_d = rx_wake_pkg::ST_IDLE;
    endcase
    // either trigger puts the sequence back to waiting
    if (stop_trig || start_trig || !chan_en_q) state_d = rx_wake_pkg::ST_IDLE;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= rx_wake_pkg::ST_IDLE;
      rx_prev_q <= 1'b1;
    end else begin
      state_q <= state_d;
      rx_prev_q <= rx_s;
    end
  end

  // shift register; a stop leaves it untouched, lsb first on the line
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      shift_q <= 8'h00;
      bitcnt_q <= 3'h0;
      par_bit_q <= 1'b0;
    end else begin
      if (state_q == rx_wake_pkg::ST_START) bitcnt_q <= 3'h0;
      if (state_q == rx_wake_pkg::ST_DATA && smp && !stop_trig) begin
        shift_q <= {rx_s, shift_q[7:1]};
        bitcnt_q <= bitcnt_q + 3'h1;
      end
      if (state_q == rx_wake_pkg::ST_PARITY && smp && !stop_trig) par_bit_q <= rx_s;
    end
  end

  // control registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      {errsel_q, wake_q} <= rx_wake_pkg::STANDBY_RESET;
      {par_odd_q, par_en_q} <= rx_wake_pkg::FRAME_CFG_RESET;
      div_q <= DIV_W'(rx_wake_pkg::DIV_RESET);
      irq_en_q <= rx_wake_pkg::IRQ_EN_RESET;
    end else begin
      if (wr_ctrl) begin
        wake_q <= req.wdata[rx_wake_pkg::WAKE_BIT];
        errsel_q <= req.wdata[rx_wake_pkg::ERRSEL_BIT];
      end
      if (wr_cfg) begin
        par_en_q <= req.wdata[rx_wake_pkg::PAR_EN_BIT];
        par_odd_q <= req.wdata[rx_wake_pkg::PAR_ODD_BIT];
      end
      if (wr_data_buf) div_q <= req.wdata[rx_wake_pkg::DIV_LSB +: DIV_W];
      if (wr_irq_en) irq_en_q <= req.wdata[rx_wake_pkg::IRQ_W-1:0];
    end
  end

  // channel enable: start sets, stop clears
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      chan_en_q <= 1'b0;
    end else if (stop_trig) begin
      chan_en_q <= 1'b0;
    end else if (start_trig) begin
      chan_en_q <= 1'b1;
    end
  end

  // byte lands in the buffer; buffer fill set wins over a read
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rx_data_q <= 8'h00;
      full_q <= 1'b0;
    end else begin
      if (frame_done) rx_data_q <= shift_q;
      full_q <= frame_done || (full_q && !rd_data_buf);
    end
  end

  // error flags survive a stop trigger; new errors beat a clear
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      err_q <= '0;
    end else begin
      err_q.fef <= (frame_done && fe_now) || (err_q.fef && !(wr_err_clr && req.wdata[0]));
      err_q.pef <= (frame_done && pe_now) || (err_q.pef && !(wr_err_clr && req.wdata[1]));
      err_q.ovf <= (frame_done && ovf_now) || (err_q.ovf && !(wr_err_clr && req.wdata[2]));
    end
  end

  // clock request: raised on a start seen in stop state
  wire req_drop = !wake_q || false_start || !stop_mode || stop_trig ||
                  (in_stop_bit && errsel_q && frame_err);
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      clk_req_q <= 1'b0;
    end else if (start_det && stop_mode && wake_q) begin
      clk_req_q <= 1'b1;
    end else if (req_drop) begin
      clk_req_q <= 1'b0;
    end
  end
  assign clk_req = clk_req_q;

  // sticky interrupt status; an event in the clear cycle is kept
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irq_st_q <= '0;
    end else begin
      irq_st_q <= irq_ev | (irq_st_q & ~(wr_irq_clr ? req.wdata[rx_wake_pkg::IRQ_W-1:0] : '0));
    end
  end
  assign irq = |(irq_st_q & irq_en_q);

  // read mux; write-only and unmapped addresses read zero
  wire [15:0] rd_mux =
    (req.addr == rx_wake_pkg::OFS_STANDBY_CTRL) ? {14'h0000, errsel_q, wake_q} :
    (req.addr == rx_wake_pkg::OFS_DATA_BUF) ? {div_q, 1'b0, rx_data_q} :
    (req.addr == rx_wake_pkg::OFS_FRAME_CFG) ? {14'h0000, par_odd_q, par_en_q} :
    (req.addr == rx_wake_pkg::OFS_CHAN_STATUS) ?
      {10'h000, state_q != rx_wake_pkg::ST_IDLE, clk_req_q, err_q, chan_en_q} :
    (req.addr == rx_wake_pkg::OFS_IRQ_STATUS) ? {14'h0000, irq_st_q} :
    (req.addr == rx_wake_pkg::OFS_IRQ_ENABLE) ? {14'h0000, irq_en_q} : 16'h0000;

  // data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data_q <= 16'h0000;
    end else begin
      rd_data_q <= req.rd ? rd_mux : 16'h0000;
    end
  end
  assign rd_data = rd_data_q;

  // checks
  sequence s_start_in_stop;
    start_det && stop_mode && wake_q;
  endsequence
  sequence s_err_frame;
    in_stop_bit && frame_err && !stop_trig;
  endsequence

  a_wake_off_idle: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_q == rx_wake_pkg::ST_IDLE && stop_mode && !wake_q |=> state_q == rx_wake_pkg::ST_IDLE)
    else $error("reception started in stop state with wake off");
  a_wake_on_start: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_start_in_stop |=> state_q == rx_wake_pkg::ST_START)
    else $error("start bit ignored in stop state with wake on");
  // request raised in the cycle after the start is seen
  a_req_rise: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_start_in_stop ##1 (stop_mode && wake_q && !smp && !stop_trig) |-> clk_req_q)
    else $error("clock request not raised on start bit");
  a_false_start_drop: assert property (@(posedge sys_clk) disable iff (!rstn)
    false_start |=> !clk_req_q && state_q == rx_wake_pkg::ST_IDLE)
    else $error("false start kept clock request");
  a_wake_clr_drop: assert property (@(posedge sys_clk) disable iff (!rstn)
    wr_ctrl && !req.wdata[rx_wake_pkg::WAKE_BIT] |=> ##1 !clk_req_q)
    else $error("clock request survives wake clear");
  // error frame with select 1 drops request, no error interrupt
  a_sel1_err_drop: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_err_frame ##0 errsel_q && !irq_st_q[rx_wake_pkg::IRQ_ERR_BIT] |=>
    !clk_req_q && !irq_st_q[rx_wake_pkg::IRQ_ERR_BIT])
    else $error("error frame with select 1 mishandled");
  // error frame with select 0 raises error interrupt
  a_sel0_err_irq: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_err_frame ##0 !errsel_q |=> irq_st_q[rx_wake_pkg::IRQ_ERR_BIT])
    else $error("error interrupt missing with select 0");
  a_start_trig: assert property (@(posedge sys_clk) disable iff (!rstn)
    start_trig |=> chan_en_q && state_q == rx_wake_pkg::ST_IDLE)
    else $error("start trigger did not enable channel");
  // stop trigger keeps flags and buffer
  a_stop_keeps: assert property (@(posedge sys_clk) disable iff (!rstn)
    stop_trig |=> !chan_en_q && $stable(err_q) && $stable(rx_data_q) && $stable(shift_q))
    else $error("stop trigger disturbed held state");
  a_rd_byte: assert property (@(posedge sys_clk) disable iff (!rstn)
    rd_data_buf |=> rd_data[7:0] == $past(rx_data_q) ##1 rd_data == 16'h0000 || $past(req.rd))
    else $error("data buffer read mismatch");
  // frame end places the byte and marks the buffer full
  a_byte_lands: assert property (@(posedge sys_clk) disable iff (!rstn)
    frame_done |=> rx_data_q == $past(shift_q) && full_q)
    else $error("received byte not placed in buffer");
  // first mid-bit sample within the longest half bit
  a_bit_sample: assert property (@(posedge sys_clk) disable iff (!rstn)
    start_det |-> ##[1:128] smp)
    else $error("no bit sample after start detect");
  // stop trigger returns the sequence to idle
  a_stop_idles: assert property (@(posedge sys_clk) disable iff (!rstn)
    stop_trig |=> state_q == rx_wake_pkg::ST_IDLE && !clk_req_q)
    else $error("stop trigger left the channel running");
endmodule
`default_nettype wire

/* tb/rx_line_model.sv */
// serial transmitter model driving the receive pin of the channel
// assumes its tasks are called just after a rising edge of sys_clk
`timescale 1ns/10ps
`default_nettype none
module rx_line_model (
  input wire logic sys_clk, // operation clock, paces the bits
  output logic rxd // receive line, idles high (mark)
);
  initial rxd = 1'b1;

  // one bit held for bclk cycles, changed just after an edge
  task automatic put_bit(input logic v, input int bclk);
    rxd <= v;
    repeat (bclk) @(posedge sys_clk);
  endtask

  // start, eight data bits lsb first, stop; bad_stop sends a low stop bit
  task automatic send(input logic [7:0] b, input int bclk, input logic bad_stop);
    put_bit(1'b0, bclk);
    for (int i = 0; i < 8; i++) begin
      put_bit(b[i], bclk);
    end
    put_bit(~bad_stop, bclk);
    rxd <= 1'b1;
  endtask

  // start, eight data bits lsb first, the given parity bit, good stop
  task automatic send_par(input logic [7:0] b, input int bclk, input logic p);
    put_bit(1'b0, bclk);
    for (int i = 0; i < 8; i++) begin
      put_bit(b[i], bclk);
    end
    put_bit(p, bclk);
    put_bit(1'b1, bclk);
  endtask

  // low pulse far shorter than half a bit, so a receiver must drop it
  task automatic glitch(input int n);
    put_bit(1'b0, n);
    rxd <= 1'b1;
  endtask
endmodule
`default_nettype wire

/* tb/rx_wake_ctrl_tb.sv */
// self-checking bench for the standby-wake receive channel
// assumes the design files and the line model are compiled before it
`timescale 1ns/10ps
`default_nettype none
module rx_wake_ctrl_tb;
  localparam logic [6:0] DIV = 7'h03; // bit time 2*(DIV+1) = 8 clocks
  localparam int BCLK = 8;
  logic sys_clk, rstn, wr_stb, rd_stb, stop_mode, rxd, clk_req, irq, rd_q1;
  logic [7:0] addr, b;
  logic [15:0] wr_data, rd_data;
  logic [31:0] seed;
  logic [31:0] exp_q[$];
  logic [7:0] zaddr [5];
  int err_count, compares;

  rx_wake_ctrl i_rx_wake_ctrl (.sys_clk(sys_clk), .rstn(rstn), .addr(addr), .wr_data(wr_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .stop_mode(stop_mode), .rxd(rxd),
    .clk_req(clk_req), .irq(irq));
  rx_line_model i_rx_line_model (.sys_clk(sys_clk), .rxd(rxd));

  // free-running 125 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic fail(input logic [15:0] got, input logic [15:0] exp);
    err_count++;
    $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
  endtask

  // level outputs are compared as they stand when called, in some checks one cycle after they change
  task automatic chk_lvl(input logic got, input logic exp);
    compares++;
    if (got !== exp) fail({15'h0, got}, {15'h0, exp});
  endtask

  // a read note carries a mask in the upper half, so volatile fields can be skipped
  task automatic chk_rd(input logic [31:0] e);
    compares++;
    if ((rd_data & e[31:16]) !== e[15:0]) fail(rd_data & e[31:16], e[15:0]);
  endtask

  // bus cycles leave a gap so no strobe is assigned twice in one step
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    addr <= a;
    rd_stb <= 1'b1;
    exp_q.push_back({m, e});
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic frame(input logic [7:0] v, input int bclk, input logic bad);
    i_rx_line_model.send(v, bclk, bad);
    repeat (6) @(posedge sys_clk);
  endtask

  // bounded wait for the clock request to reach a level
  task automatic wait_req(input logic v, input int n);
    int i;
    i = 0;
    while (clk_req !== v && i < n) begin
      @(posedge sys_clk);
      i++;
    end
    chk_lvl(clk_req, v);
  endtask

  // read data stand only in the cycle after the strobe, checked there
  always @(posedge sys_clk) begin
    if (rd_q1 === 1'b1) begin
      chk_rd(exp_q.pop_front());
    end
    rd_q1 <= rd_stb;
  end

  task automatic conclude();
    // a note still queued means a read answer was never checked
    if (exp_q.size() != 0) err_count++;
    $display("counts: compares=%0d mismatches=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // watchdog, far beyond the roughly 1100 cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    conclude();
  end

  initial begin
    rstn = 1'b0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    addr = 8'h00;
    wr_data = 16'h0000;
    stop_mode = 1'b0;
    seed = 32'ha217;
    zaddr = '{rx_wake_pkg::OFS_STANDBY_CTRL, rx_wake_pkg::OFS_IRQ_ENABLE,
      rx_wake_pkg::OFS_CHAN_STATUS, rx_wake_pkg::OFS_START_TRIG, 8'h30};
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    // reset values; write-only and unmapped places read as zero
    foreach (zaddr[i]) rd(zaddr[i], 16'hffff, 16'h0000);
    wr(rx_wake_pkg::OFS_DATA_BUF, {DIV, 9'h000});
    wr(rx_wake_pkg::OFS_IRQ_ENABLE, 16'h0003);
    rd(rx_wake_pkg::OFS_IRQ_ENABLE, 16'hffff, 16'h0003);
    wr(rx_wake_pkg::OFS_STANDBY_CTRL, 16'h0003);
    rd(rx_wake_pkg::OFS_STANDBY_CTRL, 16'hffff, 16'h0003);
    wr(rx_wake_pkg::OFS_STANDBY_CTRL, 16'h0000);
    $display("registers test done");
    // a zero in the trigger bit must leave the channel off
    wr(rx_wake_pkg::OFS_START_TRIG, 16'hfffd);
    rd(rx_wake_pkg::OFS_CHAN_STATUS, 16'h0001, 16'h0000);
    wr(rx_wake_pkg::OFS_START_TRIG, 16'h0002);
    rd(rx_wake_pkg::OFS_CHAN_STATUS, 16'h0001, 16'h0001);
    $display("start trigger test done");
    // random bytes with the device awake
    for (int k = 0; k < 3; k++) begin
      seed = lfsr_next(seed);
      frame(seed[7:0], BCLK, 1'b0);
      chk_lvl(irq, 1'b1);
      rd(rx_wake_pkg::OFS_IRQ_STATUS, 16'hffff, 16'h0001);
      rd(rx_wake_pkg::OFS_DATA_BUF, 16'hffff, {DIV, 1'b0, seed[7:0]});
      wr(rx_wake_pkg::OFS_IRQ_CLEAR, 16'h0003);
      chk_lvl(irq, 1'b0);
    end
    $display("awake receive test done");
    // stop state without wake: the frame must be ignored
    stop_mode <= 1'b1;
    seed = lfsr_next(seed);
    frame(seed[7:0], BCLK, 1'b0);
    chk_lvl(clk_req, 1'b0);
    rd(rx_wake_pkg::OFS_IRQ_STATUS, 16'hffff, 16'h0000);
    // stop state with wake: start bit raises the request, which then stays
    wr(rx_wake_pkg::OFS_STANDBY_CTRL, 16'h0001);
    seed = lfsr_next(seed);
    b = seed[7:0];
    fork
      frame(b, BCLK, 1'b0);
      wait_req(1'b1, 40);
    join
    chk_lvl(clk_req, 1'b1);
    rd(rx_wake_pkg::OFS_DATA_BUF, 16'h00ff, {8'h00, b});
    wr(rx_wake_pkg::OFS_IRQ_CLEAR, 16'h0003);
    wr(rx_wake_pkg::OFS_STANDBY_CTRL, 16'h0000);
    // the request falls one cycle after the wake bit does
    @(posedge sys_clk);
    chk_lvl(clk_req, 1'b0);
    $display("stop state wake test done");
    // false start drops the request again
    wr(rx_wake_pkg::OFS_STANDBY_CTRL, 16'h0001);
    fork
      i_rx_line_model.glitch(2);
      wait_req(1'b1, 8);
    join
    repeat (12) @(posedge sys_clk);
    chk_lvl(clk_req, 1'b0);
    // select 1: framing error drops the request and raises no interrupt
    wr(rx_wake_pkg::OFS_STANDBY_CTRL, 16'h0003);
    fork
      frame(b, BCLK, 1'b1);
      wait_req(1'b1, 40);
    join
    chk_lvl(clk_req, 1'b0);
    rd(rx_wake_pkg::OFS_IRQ_STATUS, 16'hffff, 16'h0000);
    rd(rx_wake_pkg::OFS_CHAN_STATUS, 16'h0003, 16'h0003);
    wr(rx_wake_pkg::OFS_ERR_CLEAR, 16'h0007);
    rd(rx_wake_pkg::OFS_DATA_BUF, 16'h00ff, {8'h00, b});
    // select 0: the same error raises the error interrupt
    stop_mode <= 1'b0;
    wr(rx_wake_pkg::OFS_STANDBY_CTRL, 16'h0000);
    frame(b, BCLK, 1'b1);
    rd(rx_wake_pkg::OFS_IRQ_STATUS, 16'hffff, 16'h0002);
    chk_lvl(irq, 1'b1);
    $display("error handling test done");
    // stop trigger: channel off, framing flag kept, line ignored
    wr(rx_wake_pkg::OFS_STOP_TRIG, 16'h0002);
    rd(rx_wake_pkg::OFS_CHAN_STATUS, 16'h000f, 16'h0002);
    rd(rx_wake_pkg::OFS_DATA_BUF, 16'h00ff, {8'h00, b});
    wr(rx_wake_pkg::OFS_IRQ_CLEAR, 16'h0003);
    frame(8'h55, BCLK, 1'b0);
    rd(rx_wake_pkg::OFS_IRQ_STATUS, 16'hffff, 16'h0000);
    $display("stop trigger test done");
    // a sender one clock slow per bit drifts past mid-bit without realignment
    wr(rx_wake_pkg::OFS_START_TRIG, 16'h0002);
    wr(rx_wake_pkg::OFS_STANDBY_CTRL, 16'h0001);
    frame(8'h55, BCLK + 1, 1'b0);
    rd(rx_wake_pkg::OFS_DATA_BUF, 16'hffff, {DIV, 1'b0, 8'h55});
    $display("baud adjust test done");
    // odd then even parity; the second frame also finds the buffer unread
    wr(rx_wake_pkg::OFS_IRQ_CLEAR, 16'h0003);
    wr(rx_wake_pkg::OFS_ERR_CLEAR, 16'h0007);
    wr(rx_wake_pkg::OFS_FRAME_CFG, 16'h0003);
    rd(rx_wake_pkg::OFS_FRAME_CFG, 16'hffff, 16'h0003);
    seed = lfsr_next(seed);
    b = seed[7:0];
    i_rx_line_model.send_par(b, BCLK, ~^b);
    repeat (6) @(posedge sys_clk);
    rd(rx_wake_pkg::OFS_IRQ_STATUS, 16'hffff, 16'h0001);
    wr(rx_wake_pkg::OFS_FRAME_CFG, 16'h0001);
    i_rx_line_model.send_par(b, BCLK, ~^b);
    repeat (6) @(posedge sys_clk);
    rd(rx_wake_pkg::OFS_IRQ_STATUS, 16'hffff, 16'h0003);
    rd(rx_wake_pkg::OFS_CHAN_STATUS, 16'h000e, 16'h000c);
    $display("parity and overrun test done");
    // let the last read answer be checked before the verdict
    repeat (2) @(posedge sys_clk);
    conclude();
  end
endmodule
`default_nettype wire
